// ===== pbc_pkg.sv
package pbc_pkg;

   // Register map: the basic control register is the only one this block decodes; reads of other addresses are answered with zero.
   localparam logic [4:0] PBC_ADDR_BASIC_CONTROL = 5'h00;

   // Field positions inside the basic control register.
   localparam int PBC_BIT_SOFT_RESET = 15;
   localparam int PBC_BIT_LOOPBACK = 14;
   localparam int PBC_BIT_SPEED_100 = 13;
   localparam int PBC_BIT_AN_ENABLE = 12;
   localparam int PBC_BIT_POWER_DOWN = 11;
   localparam int PBC_BIT_ISOLATE = 10;
   localparam int PBC_BIT_AN_RESTART = 9;
   localparam int PBC_BIT_FULL_DUPLEX = 8;
   localparam int PBC_BIT_COLL_TEST = 7;
   localparam int PBC_RSVD_MSB = 6;

   // Reset values of the individual fields.
   localparam logic PBC_RST_LOOPBACK = 1'b0;
   localparam logic PBC_RST_SPEED_100 = 1'b1;
   localparam logic PBC_RST_AN_ENABLE = 1'b1;
   localparam logic PBC_RST_POWER_DOWN = 1'b0;
   localparam logic PBC_RST_ISOLATE = 1'b0;
   localparam logic PBC_RST_AN_RESTART = 1'b0;
   localparam logic PBC_RST_FULL_DUPLEX = 1'b1;
   localparam logic PBC_RST_COLL_TEST = 1'b0;
   localparam logic [15:0] PBC_RST_DATA_ZERO = 16'h0000;
   localparam logic [6:0] PBC_RSVD_ZERO = 7'h00;

   // Clock period and the timing figures derived from it.
   localparam int PBC_CLK_PERIOD_NS = 100;
   localparam int PBC_SRST_TIME_NS = 1000;
   localparam int PBC_SRST_CYCLES =
      (PBC_SRST_TIME_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;
   localparam int PBC_DEAD_TIME_MS = 720;
   localparam int PBC_DEAD_CYCLES = PBC_DEAD_TIME_MS * (1000000 / PBC_CLK_PERIOD_NS);
   localparam int PBC_SRST_CW = 4;

   // Phases of the software reset process.
   typedef enum logic {
      PBC_ST_RUN,
      PBC_ST_SRST
   } pbc_state_e;

endpackage : pbc_pkg

// ===== pbc_dead_timer.sv
`timescale 1ns/1ps

module pbc_dead_timer
   import pbc_pkg::*;
#(
   parameter int DEAD_CYCLES = PBC_DEAD_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control.
   input wire logic start,
   input wire logic clear,
   // Status.
   output logic blocked
);

   localparam int CW = $clog2(DEAD_CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(DEAD_CYCLES);
   localparam logic [CW-1:0] ONE = CW'(1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic next_blocked;

   // Counts the receive dead interval; a new start reloads the full interval.
   always_comb begin
      next_count = count;
      next_blocked = blocked;
      if (clear) begin
         next_count = '0;
         next_blocked = 1'b0;
      end else if (start) begin
         next_count = LOAD;
         next_blocked = 1'b1;
      end else if (blocked) begin
         next_count = count - ONE;
         next_blocked = (count != ONE);
      end
   end

   // Registers of the timer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         count <= '0;
         blocked <= 1'b0;
      end else begin
         count <= next_count;
         blocked <= next_blocked;
      end
   end

   dead_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      start && !clear |=> blocked && count == LOAD)
      else $error("Dead interval did not start on loopback entry.");

   dead_tick_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      blocked && !start && !clear && count > ONE |=> blocked && count == $past(count) - ONE)
      else $error("Dead interval counter did not step down.");

endmodule : pbc_dead_timer

// ===== pbc_basic_control.sv
`timescale 1ns/1ps

module pbc_basic_control
   import pbc_pkg::*;
#(
   parameter int DEAD_CYCLES = PBC_DEAD_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Management register access.
   input wire logic mg_wr,
   input wire logic mg_rd,
   input wire logic [4:0] mg_addr,
   input wire logic [15:0] mg_wdata,
   output logic [15:0] mg_rdata,
   output logic mg_rvalid,
   // Auto-negotiation state machine.
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   input wire logic an_started,
   output logic an_enable,
   output logic an_restart,
   // PHY datapath controls.
   input wire logic tx_active,
   output logic loopback,
   output logic speed_100,
   output logic full_duplex,
   output logic power_down,
   output logic isolate,
   output logic collision,
   output logic rx_blocked,
   output logic regs_reset
);

   localparam logic [PBC_SRST_CW-1:0] SRST_LOAD = PBC_SRST_CW'(PBC_SRST_CYCLES);
   localparam logic [PBC_SRST_CW-1:0] SRST_ONE = PBC_SRST_CW'(1);

   // Chooses the negotiated value while negotiation is on, else the written one.
   function automatic logic pbc_pick(input logic an_on, input logic negotiated,
                                     input logic written);
      pbc_pick = an_on ? negotiated : written;
   endfunction : pbc_pick

   // Control state.
   pbc_state_e state;
   pbc_state_e next_state;
   logic [PBC_SRST_CW-1:0] srst_cnt;
   logic [PBC_SRST_CW-1:0] next_srst_cnt;
   logic speed_sel;
   logic next_speed_sel;
   logic dup_sel;
   logic next_dup_sel;
   logic coll_test;
   logic next_coll_test;
   logic next_loopback;
   logic next_an_enable;
   logic next_power_down;
   logic next_isolate;
   logic next_an_restart;
   logic next_regs_reset;

   // Read path and derived outputs.
   logic [15:0] next_mg_rdata;
   logic next_mg_rvalid;
   logic next_speed_100;
   logic next_full_duplex;
   logic next_collision;
   logic ctl_hit;
   logic wr_hit;
   logic dead_start;
   logic [15:0] read_word;

   assign ctl_hit = (mg_addr == PBC_ADDR_BASIC_CONTROL);
   assign wr_hit = mg_wr && ctl_hit && (state == PBC_ST_RUN);

   // Next values of the control fields and the software reset sequencer.
   always_comb begin
      next_state = state;
      next_srst_cnt = srst_cnt;
      next_loopback = loopback;
      next_speed_sel = speed_sel;
      next_an_enable = an_enable;
      next_power_down = power_down;
      next_isolate = isolate;
      next_an_restart = an_restart;
      next_dup_sel = dup_sel;
      next_coll_test = coll_test;
      // The device acknowledges a pending restart once negotiation is under way.
      if (an_restart && an_started) begin
         next_an_restart = 1'b0;
      end
      if (state == PBC_ST_SRST) begin
         // Fields sit at defaults for the whole reset; writes are ignored meanwhile.
         next_srst_cnt = srst_cnt - SRST_ONE;
         if (srst_cnt == SRST_ONE) begin
            next_state = PBC_ST_RUN;
         end
      end else if (wr_hit && mg_wdata[PBC_BIT_SOFT_RESET]) begin
         next_state = PBC_ST_SRST;
         next_srst_cnt = SRST_LOAD;
         next_loopback = PBC_RST_LOOPBACK;
         next_speed_sel = PBC_RST_SPEED_100;
         next_an_enable = PBC_RST_AN_ENABLE;
         next_power_down = PBC_RST_POWER_DOWN;
         next_isolate = PBC_RST_ISOLATE;
         next_an_restart = PBC_RST_AN_RESTART;
         next_dup_sel = PBC_RST_FULL_DUPLEX;
         next_coll_test = PBC_RST_COLL_TEST;
      end else if (wr_hit) begin
         next_loopback = mg_wdata[PBC_BIT_LOOPBACK];
         next_speed_sel = mg_wdata[PBC_BIT_SPEED_100];
         next_an_enable = mg_wdata[PBC_BIT_AN_ENABLE];
         next_power_down = mg_wdata[PBC_BIT_POWER_DOWN];
         next_isolate = mg_wdata[PBC_BIT_ISOLATE];
         next_dup_sel = mg_wdata[PBC_BIT_FULL_DUPLEX];
         next_coll_test = mg_wdata[PBC_BIT_COLL_TEST];
         // A restart request only counts with negotiation on; a written zero only
         // withdraws the request and never stops a negotiation already running.
         next_an_restart = mg_wdata[PBC_BIT_AN_RESTART]
                           && mg_wdata[PBC_BIT_AN_ENABLE];
      end
   end

   // Registers of the control fields.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state <= PBC_ST_RUN;
         srst_cnt <= '0;
         loopback <= PBC_RST_LOOPBACK;
         speed_sel <= PBC_RST_SPEED_100;
         an_enable <= PBC_RST_AN_ENABLE;
         power_down <= PBC_RST_POWER_DOWN;
         isolate <= PBC_RST_ISOLATE;
         an_restart <= PBC_RST_AN_RESTART;
         dup_sel <= PBC_RST_FULL_DUPLEX;
         coll_test <= PBC_RST_COLL_TEST;
      end else begin
         state <= next_state;
         srst_cnt <= next_srst_cnt;
         loopback <= next_loopback;
         speed_sel <= next_speed_sel;
         an_enable <= next_an_enable;
         power_down <= next_power_down;
         isolate <= next_isolate;
         an_restart <= next_an_restart;
         dup_sel <= next_dup_sel;
         coll_test <= next_coll_test;
      end
   end

   // Word seen by a read; speed and duplex follow negotiation while it is on.
   always_comb begin
      read_word = PBC_RST_DATA_ZERO;
      read_word[PBC_BIT_SOFT_RESET] = (state == PBC_ST_SRST);
      read_word[PBC_BIT_LOOPBACK] = loopback;
      read_word[PBC_BIT_SPEED_100] = pbc_pick(an_enable, an_speed_100, speed_sel);
      read_word[PBC_BIT_AN_ENABLE] = an_enable;
      read_word[PBC_BIT_POWER_DOWN] = power_down;
      read_word[PBC_BIT_ISOLATE] = isolate;
      read_word[PBC_BIT_AN_RESTART] = an_restart;
      read_word[PBC_BIT_FULL_DUPLEX] = pbc_pick(an_enable, an_full_duplex, dup_sel);
      read_word[PBC_BIT_COLL_TEST] = coll_test;
      read_word[PBC_RSVD_MSB:0] = PBC_RSVD_ZERO;
   end

   // Next values of the read port and the registered datapath controls.
   always_comb begin
      next_mg_rvalid = mg_rd;
      next_mg_rdata = mg_rdata;
      if (mg_rd) begin
         next_mg_rdata = ctl_hit ? read_word : PBC_RST_DATA_ZERO;
      end
      next_speed_100 = pbc_pick(next_an_enable, an_speed_100, next_speed_sel);
      next_full_duplex = pbc_pick(next_an_enable, an_full_duplex, next_dup_sel);
      next_collision = coll_test && tx_active;
      next_regs_reset = (next_state == PBC_ST_SRST);
   end

   // Registers of the read port and datapath controls.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mg_rdata <= PBC_RST_DATA_ZERO;
         mg_rvalid <= 1'b0;
         speed_100 <= PBC_RST_SPEED_100;
         full_duplex <= PBC_RST_FULL_DUPLEX;
         collision <= 1'b0;
         regs_reset <= 1'b0;
      end else begin
         mg_rdata <= next_mg_rdata;
         mg_rvalid <= next_mg_rvalid;
         speed_100 <= next_speed_100;
         full_duplex <= next_full_duplex;
         collision <= next_collision;
         regs_reset <= next_regs_reset;
      end
   end

   // Entering loopback at 100 Mbps can upset the descrambler, so receive waits.
   assign dead_start = next_loopback && !loopback && speed_100;

   pbc_dead_timer #(
      .DEAD_CYCLES(DEAD_CYCLES)
   ) pbc_dead_timer_inst (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(dead_start),
      .clear(next_regs_reset),
      .blocked(rx_blocked)
   );

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_n);

   srst_entry_a: assert property (
      wr_hit && mg_wdata[PBC_BIT_SOFT_RESET] |=> regs_reset && !loopback && an_enable
         && speed_sel && dup_sel && !power_down && !isolate && !an_restart && !coll_test)
      else $error("Software reset did not restore the default fields.");

   srst_length_a: assert property (
      $rose(regs_reset) |-> ##9 regs_reset ##1 !regs_reset)
      else $error("Software reset did not last its full length.");

   srst_readback_a: assert property (
      mg_rd && ctl_hit && state == PBC_ST_SRST |=> mg_rvalid && mg_rdata[PBC_BIT_SOFT_RESET])
      else $error("Reset bit did not read one during the reset process.");

   srst_done_a: assert property (
      $fell(regs_reset) |-> state == PBC_ST_RUN && an_enable && speed_sel && dup_sel
         && !loopback && !an_restart)
      else $error("Fields not at defaults when software reset finished.");

   loop_write_a: assert property (
      wr_hit && !mg_wdata[PBC_BIT_SOFT_RESET] |=> loopback == $past(mg_wdata[PBC_BIT_LOOPBACK]))
      else $error("Loopback field did not take the written value.");

   speed_read_a: assert property (
      mg_rd && ctl_hit && an_enable && state == PBC_ST_RUN
         |=> mg_rdata[PBC_BIT_SPEED_100] == $past(an_speed_100))
      else $error("Speed read did not follow the negotiated speed.");

   duplex_read_a: assert property (
      mg_rd && ctl_hit && !an_enable |=> mg_rdata[PBC_BIT_FULL_DUPLEX] == $past(dup_sel))
      else $error("Duplex read did not show the written value with negotiation off.");

   restart_set_a: assert property (
      wr_hit && !mg_wdata[PBC_BIT_SOFT_RESET] && mg_wdata[PBC_BIT_AN_RESTART]
         && mg_wdata[PBC_BIT_AN_ENABLE] |=> an_restart)
      else $error("Restart request was not raised.");

   restart_hold_a: assert property (
      an_restart && !an_started && !mg_wr && state == PBC_ST_RUN |=> an_restart)
      else $error("Restart cleared before negotiation started.");

   power_answer_a: assert property (
      mg_rd && power_down |=> mg_rvalid)
      else $error("Management read not answered while powered down.");

   coll_test_a: assert property (
      coll_test && tx_active |=> collision)
      else $error("Collision not raised during transmit under collision test.");

   reserved_zero_a: assert property (
      mg_rvalid |-> mg_rdata[PBC_RSVD_MSB:0] == PBC_RSVD_ZERO)
      else $error("Reserved bits did not read zero.");

   duplex_neg_a: assert property (
      mg_rd && ctl_hit && an_enable
         |=> mg_rdata[PBC_BIT_FULL_DUPLEX] == $past(an_full_duplex))
      else $error("Duplex read did not follow the negotiated duplex.");

   speed_fixed_a: assert property (
      !an_enable |-> speed_100 == speed_sel)
      else $error("Speed output did not follow the written speed.");

   duplex_fixed_a: assert property (
      !an_enable |-> full_duplex == dup_sel)
      else $error("Duplex output did not follow the written duplex.");

   restart_refuse_a: assert property (
      wr_hit && !mg_wdata[PBC_BIT_AN_ENABLE] |=> !an_restart)
      else $error("Restart request taken with negotiation off.");

   coll_quiet_a: assert property (
      !coll_test |=> !collision)
      else $error("Collision raised without collision test.");

endmodule : pbc_basic_control

// ===== pbc_an_model.sv
`timescale 1ns/1ps

// Stand-in for the negotiation logic: acknowledges a restart request after a set delay.
module pbc_an_model
   import pbc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Requests from the control register.
   input wire logic an_enable,
   input wire logic an_restart,
   // Delay in cycles before the restart is acknowledged.
   input wire logic [3:0] latency,
   // Acknowledge back to the control register.
   output logic an_started
);
   logic [3:0] wait_cnt;
   logic [3:0] next_wait_cnt;
   logic next_an_started;

   // The pulse is one cycle wide; a request still held after it is acknowledged again once the delay has run.
   always_comb begin
      next_wait_cnt = wait_cnt;
      next_an_started = 1'b0;
      if (!an_restart || !an_enable || an_started) begin
         next_wait_cnt = 4'h0;
      end else if (wait_cnt == latency) begin
         next_an_started = 1'b1;
      end else begin
         next_wait_cnt = wait_cnt + 4'h1;
      end
   end

   // State registers of the model.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wait_cnt <= 4'h0;
         an_started <= 1'b0;
      end else begin
         wait_cnt <= next_wait_cnt;
         an_started <= next_an_started;
      end
   end
endmodule : pbc_an_model

// ===== pbc_basic_control_test.sv
`timescale 1ns/1ps

module pbc_basic_control_test;
   import pbc_pkg::*;
   localparam int DEAD = 20;
   localparam int LIMIT = 2000;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic mg_wr = 1'b0;
   logic mg_rd = 1'b0;
   logic [4:0] mg_addr = 5'h00;
   logic [15:0] mg_wdata = 16'h0000;
   logic an_speed_100 = 1'b1;
   logic an_full_duplex = 1'b1;
   logic tx_active = 1'b0;
   logic [3:0] latency = 4'h6;
   logic [15:0] mg_rdata;
   logic [15:0] rv;
   logic mg_rvalid, an_started, an_enable, an_restart, loopback, speed_100;
   logic full_duplex, power_down, isolate, collision, rx_blocked, regs_reset;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;

   pbc_basic_control #(.DEAD_CYCLES(DEAD)) pbc_basic_control_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .mg_wr(mg_wr), .mg_rd(mg_rd),
      .mg_addr(mg_addr), .mg_wdata(mg_wdata), .mg_rdata(mg_rdata), .mg_rvalid(mg_rvalid),
      .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
      .an_started(an_started), .an_enable(an_enable), .an_restart(an_restart),
      .tx_active(tx_active), .loopback(loopback), .speed_100(speed_100),
      .full_duplex(full_duplex), .power_down(power_down), .isolate(isolate),
      .collision(collision), .rx_blocked(rx_blocked), .regs_reset(regs_reset));

   pbc_an_model pbc_an_model_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .an_enable(an_enable), .an_restart(an_restart),
      .latency(latency), .an_started(an_started));

   // Free-running bench clock at 10 MHz.
   always #50 sys_clk = ~sys_clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // A hang is cut short here and counted as a mismatch.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         close_out();
      end
   end

   // Compares a word seen against the value worked out by the bench.
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Same comparison for a single status line.
   task automatic chb(input string nm, input logic seen, input logic exp);
      chk(nm, {15'h0000, seen}, {15'h0000, exp});
   endtask : chb

   // Waits whole cycles, leaving the bench one step after the rising edge.
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // One write strobe; an idle cycle first keeps strobes from merging.
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      tick(1);
      mg_wr = 1'b1;
      mg_addr = a;
      mg_wdata = v;
      tick(1);
      mg_wr = 1'b0;
   endtask : wr

   // One read strobe, then a bounded wait for the answer pulse.
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      int n;
      tick(1);
      mg_rd = 1'b1;
      mg_addr = a;
      tick(1);
      mg_rd = 1'b0;
      n = 0;
      while (mg_rvalid !== 1'b1 && n < 4) begin
         tick(1);
         n++;
      end
      chb("read answer", mg_rvalid, 1'b1);
      d = mg_rdata;
   endtask : rd

   // Reads the control register and compares it with the expected word.
   task automatic rchk(input logic [15:0] exp);
      rd(PBC_ADDR_BASIC_CONTROL, rv);
      chk("control word", rv, exp);
   endtask : rchk

   // Main sequence; every word written keeps the isolate bit at zero.
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      rchk(16'h3100);
      chb("loopback", loopback, 1'b0);
      chb("an enable", an_enable, 1'b1);
      // Negotiated result differs from the stored fields.
      an_speed_100 = 1'b0;
      an_full_duplex = 1'b0;
      tick(2);
      rchk(16'h1000);
      chb("speed", speed_100, 1'b0);
      chb("duplex", full_duplex, 1'b0);
      // Slow acknowledge: restart reads one until the model answers.
      wr(PBC_ADDR_BASIC_CONTROL, 16'h1200);
      chb("restart out", an_restart, 1'b1);
      rchk(16'h1200);
      tick(12);
      rchk(16'h1000);
      chb("restart out", an_restart, 1'b0);
      // Prompt acknowledge.
      latency = 4'h0;
      wr(PBC_ADDR_BASIC_CONTROL, 16'h1200);
      tick(4);
      chb("restart out", an_restart, 1'b0);
      // Negotiation off: written speed and duplex take effect.
      wr(PBC_ADDR_BASIC_CONTROL, 16'h2000);
      rchk(16'h2000);
      chb("speed", speed_100, 1'b1);
      chb("duplex", full_duplex, 1'b0);
      chb("an enable", an_enable, 1'b0);
      wr(PBC_ADDR_BASIC_CONTROL, 16'h037F);
      rchk(16'h0100);
      chb("restart out", an_restart, 1'b0);
      chb("isolate", isolate, 1'b0);
      chb("speed", speed_100, 1'b0);
      chb("duplex", full_duplex, 1'b1);
      // Loopback entered at 100 Mbps blocks receive for the dead time.
      wr(PBC_ADDR_BASIC_CONTROL, 16'h2000);
      wr(PBC_ADDR_BASIC_CONTROL, 16'h6000);
      tick(2);
      chb("loopback", loopback, 1'b1);
      chb("rx blocked", rx_blocked, 1'b1);
      tick(DEAD - 4);
      chb("rx blocked", rx_blocked, 1'b1);
      tick(4);
      chb("rx blocked", rx_blocked, 1'b0);
      // Power down with collision test; the register still answers.
      wr(PBC_ADDR_BASIC_CONTROL, 16'h0880);
      chb("power down", power_down, 1'b1);
      rchk(16'h0880);
      tx_active = 1'b1;
      tick(2);
      chb("collision", collision, 1'b1);
      tx_active = 1'b0;
      tick(2);
      chb("collision", collision, 1'b0);
      // Other addresses read zero and ignore writes.
      wr(5'h01, 16'h0000);
      rd(5'h01, rv);
      chk("unmapped word", rv, 16'h0000);
      rchk(16'h0880);
      // Software reset; a write while it runs is dropped.
      an_speed_100 = 1'b1;
      an_full_duplex = 1'b1;
      wr(PBC_ADDR_BASIC_CONTROL, 16'h8000);
      chb("regs reset", regs_reset, 1'b1);
      rchk(16'hB100);
      wr(PBC_ADDR_BASIC_CONTROL, 16'h0800);
      tick(12);
      chb("regs reset", regs_reset, 1'b0);
      chb("power down", power_down, 1'b0);
      chb("an enable", an_enable, 1'b1);
      rchk(16'h3100);
      close_out();
   end
endmodule : pbc_basic_control_test
